/* File: pkg/vgt_pkg.sv */
/*
  Shared definitions for the video grab trigger control block: register map,
  field positions, reset values, sampling timing table and carrier structs.
  Assumes a single 100 MHz clock and a decoder stream on that same clock.
*/
package vgt_pkg;

    // Register byte addresses
    localparam logic [7:0]  VGT_ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  VGT_ADDR_CHAN   = 8'h04;
    localparam logic [7:0]  VGT_ADDR_GAIN   = 8'h08;
    localparam logic [7:0]  VGT_ADDR_STAT   = 8'h0C;
    localparam logic [7:0]  VGT_ADDR_LINE   = 8'h10;
    localparam logic [7:0]  VGT_ADDR_RATE   = 8'h14;
    localparam logic [7:0]  VGT_ADDR_FRAME  = 8'h18;

    // Control fields
    localparam int          VGT_CTRL_EN     = 0;
    localparam int          VGT_CTRL_MODE   = 1;
    localparam int          VGT_CTRL_POL    = 3;
    localparam int          VGT_CTRL_SQ     = 4;
    localparam int          VGT_CTRL_PAL    = 5;
    localparam int          VGT_CTRL_FMT    = 6;
    localparam int          VGT_CTRL_AGC    = 9;
    localparam logic [31:0] VGT_CTRL_MASK   = 32'h0000_03FF;
    localparam logic [31:0] VGT_CTRL_RESET  = 32'h0000_0208;

    // Channel and gain fields
    localparam int          VGT_CHAN_YC     = 4;
    localparam logic [31:0] VGT_CHAN_MASK   = 32'h0000_001F;
    localparam logic [31:0] VGT_GAIN_MASK   = 32'h0000_00FF;
    localparam logic [31:0] VGT_GAIN_RESET  = 32'h0000_0080;

    localparam logic [1:0]  VGT_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  VGT_RESP_SLVERR = 2'h2;

    // Sampling timing table; converter rate is twice the pixel rate
    localparam logic [9:0]  VGT_CCIR_NTSC_TOTAL = 10'h35A;
    localparam logic [9:0]  VGT_CCIR_PAL_TOTAL  = 10'h360;
    localparam logic [9:0]  VGT_CCIR_ACTIVE     = 10'h2D0;
    localparam logic [9:0]  VGT_SQ_NTSC_TOTAL   = 10'h30C;
    localparam logic [9:0]  VGT_SQ_PAL_TOTAL    = 10'h3B0;
    localparam logic [9:0]  VGT_SQ_NTSC_ACTIVE  = 10'h280;
    localparam logic [9:0]  VGT_SQ_PAL_ACTIVE   = 10'h300;
    localparam logic [9:0]  VGT_NTSC_LINES      = 10'h1E0;
    localparam logic [9:0]  VGT_PAL_LINES       = 10'h244;
    localparam logic [15:0] VGT_CCIR_PIX_KHZ    = 16'h34BC;
    localparam logic [15:0] VGT_SQ_NTSC_PIX_KHZ = 16'h2FEE;
    localparam logic [15:0] VGT_SQ_PAL_PIX_KHZ  = 16'h399E;
    localparam logic [15:0] VGT_CCIR_ADC_KHZ    = 16'h6978;
    localparam logic [15:0] VGT_SQ_NTSC_ADC_KHZ = 16'h5FDC;
    localparam logic [15:0] VGT_SQ_PAL_ADC_KHZ  = 16'h733C;

    typedef enum logic [1:0] {VGT_TRIG_FREE, VGT_TRIG_MONO, VGT_TRIG_CONT,
                              VGT_TRIG_LEVEL} vgt_trig_mode_t;
    typedef enum logic [2:0] {VGT_FMT_RGB888, VGT_FMT_RGB565, VGT_FMT_YUV422,
                              VGT_FMT_YUV411, VGT_FMT_RGB32} vgt_fmt_t;
    typedef enum logic [1:0] {VGT_IDLE, VGT_ARMED, VGT_WAIT_BOUND,
                              VGT_CAPTURE} vgt_fsm_t;

    typedef struct packed {
        logic       valid;
        logic       sof;
        logic [7:0] y;
        logic [7:0] u;
        logic [7:0] v;
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
    } vgt_video_t;

    typedef struct packed {
        logic [3:0]  channel;
        logic        yc_mode;
        logic        square;
        logic        pal;
        logic        agc_en;
        logic [7:0]  gain;
        vgt_fmt_t    fmt;
        logic [9:0]  total_px;
        logic [9:0]  active_px;
        logic [9:0]  active_lines;
        logic [15:0] pixel_khz;
        logic [15:0] adc_khz;
    } vgt_cfg_t;

    typedef struct packed {
        logic        valid;
        logic        sof;
        logic [2:0]  bytes;
        logic [31:0] data;
    } vgt_cap_t;

    typedef struct packed {
        logic [7:0]  awaddr;
        logic        aw_have;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        w_have;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [31:0] ctrl;
        logic [31:0] chan;
        logic [31:0] gain;
        logic        trig_s1;
        logic        trig_s2;
        logic        trig_prev;
        vgt_fsm_t    fsm;
        logic [1:0]  pix_idx;
        logic [15:0] frames;
        vgt_cap_t    cap;
    } vgt_state_t;

endpackage

/* File: src/vgt_grab_ctrl.sv */
/*
  Acquisition control for a frame grabber: AXI4-Lite registers, trigger
  qualification, frame-aligned capture and pixel packing.
  Assumes the decoder stream runs on aclk and marks each frame/field start
  with sof on its first valid pixel; the trigger pin is asynchronous.
*/
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Capture waits for next frame boundary
// - Monoshot: one frame per active edge
// - Continuous: edge starts endless frame capture
// - Level: capture while trigger stays active
// - Software bit selects trigger polarity
// - One software-selected channel at a time
// - Twelve composite or six luma/chroma sources
// - CCIR 601 line and rate timing
// - Square-pixel line and rate timing
// - Converter clock twice the pixel rate
// - Five selectable pixel output formats
// - YUV 4:2:2 ordered Y, U, Y, V
// - Gain control automatic by default, manual option
// - Padded RGB in one 32-bit word
module vgt_grab_ctrl #(
    parameter int NUM_COMP = 12,
    parameter int NUM_YC   = 6
) (
    // Clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // Decoder stream and trigger pin
    input  wire vgt_pkg::vgt_video_t vid,
    input  wire logic               isolated_trigger_input,
    // Decoder setup and captured pixels
    output vgt_pkg::vgt_cfg_t       cfg,
    output vgt_pkg::vgt_cap_t       cap,
    output logic                    grab_active
);
    import vgt_pkg::*;

    vgt_state_t     st;
    vgt_state_t     next_st;
    logic           trig_act;
    logic           trig_edge;
    logic           frame_start;
    logic [31:0]    cand_chan;
    vgt_trig_mode_t mode;
    vgt_fmt_t       fmt;

    function automatic logic [31:0] merge(input logic [31:0] old_w,
                                          input logic [31:0] new_w,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                res[i*8 +: 8] = new_w[i*8 +: 8];
        end
        return res;
    endfunction

    // Out-of-range selections are dropped so the mux never sees a bad code
    function automatic logic chan_ok(input logic [31:0] c);
        if (c[VGT_CHAN_YC])
            return 32'(c[3:0]) < NUM_YC;
        return 32'(c[3:0]) < NUM_COMP;
    endfunction

    function automatic vgt_cap_t pack(input vgt_fmt_t f, input vgt_video_t p,
                                      input logic [1:0] idx);
        vgt_cap_t c;
        c.valid = 1'b1;
        c.sof   = p.sof;
        c.bytes = 3'h3;
        c.data  = {8'h00, p.r, p.g, p.b};
        case (f)
            VGT_FMT_RGB565:
            begin
                c.bytes = 3'h2;
                c.data  = {16'h0000, p.r[7:3], p.g[7:2], p.b[7:3]};
            end
            VGT_FMT_YUV422:
            begin
                c.bytes = 3'h2;
                c.data  = {16'h0000, idx[0] ? p.v : p.u, p.y};
            end
            VGT_FMT_YUV411:
            begin
                c.bytes = idx[0] ? 3'h1 : 3'h2;
                c.data  = {16'h0000, idx[0] ? 8'h00 : (idx[1] ? p.v : p.u), p.y};
            end
            VGT_FMT_RGB32:
            begin
                c.bytes = 3'h4;
                c.data  = {8'h00, p.r, p.g, p.b};
            end
            default:
            begin
                c.bytes = 3'h3;
            end
        endcase
        return c;
    endfunction

    assign mode        = vgt_trig_mode_t'(st.ctrl[VGT_CTRL_MODE +: 2]);
    assign fmt         = vgt_fmt_t'(st.ctrl[VGT_CTRL_FMT +: 3]);
    assign trig_act    = st.ctrl[VGT_CTRL_POL] ? st.trig_s2 : !st.trig_s2;
    assign trig_edge   = trig_act && !st.trig_prev;
    assign frame_start = vid.valid && vid.sof;

    always_comb
    begin
        next_st   = st;
        cand_chan = merge(st.chan, st.wdata, st.wstrb) & VGT_CHAN_MASK;
        // Pin reaches logic only through the second flop
        next_st.trig_s1   = isolated_trigger_input;
        next_st.trig_s2   = st.trig_s1;
        next_st.trig_prev = trig_act;

        if (s_axi_awvalid && !st.aw_have)
        begin
            next_st.aw_have = 1'b1;
            next_st.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_have)
        begin
            next_st.w_have = 1'b1;
            next_st.wdata  = s_axi_wdata;
            next_st.wstrb  = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready)
            next_st.bvalid = 1'b0;
        if (st.aw_have && st.w_have && !st.bvalid)
        begin
            next_st.aw_have = 1'b0;
            next_st.w_have  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = VGT_RESP_OKAY;
            case (st.awaddr)
                VGT_ADDR_CTRL:
                    next_st.ctrl = merge(st.ctrl, st.wdata, st.wstrb) & VGT_CTRL_MASK;
                VGT_ADDR_CHAN:
                begin
                    if (chan_ok(cand_chan))
                        next_st.chan = cand_chan;
                end
                VGT_ADDR_GAIN:
                    next_st.gain = merge(st.gain, st.wdata, st.wstrb) & VGT_GAIN_MASK;
                VGT_ADDR_STAT, VGT_ADDR_LINE, VGT_ADDR_RATE, VGT_ADDR_FRAME:
                    next_st.bresp = VGT_RESP_OKAY;
                default:
                    next_st.bresp = VGT_RESP_SLVERR;
            endcase
        end

        if (s_axi_arvalid && !st.rvalid)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = VGT_RESP_OKAY;
            case (s_axi_araddr)
                VGT_ADDR_CTRL:  next_st.rdata = st.ctrl;
                VGT_ADDR_CHAN:  next_st.rdata = st.chan;
                VGT_ADDR_GAIN:  next_st.rdata = st.gain;
                VGT_ADDR_STAT:  next_st.rdata = {28'h000_0000, trig_act,
                                                 st.fsm == VGT_CAPTURE,
                                                 st.fsm == VGT_WAIT_BOUND,
                                                 st.fsm == VGT_ARMED};
                VGT_ADDR_LINE:  next_st.rdata = {6'h00, cfg.active_px, 6'h00,
                                                 cfg.total_px};
                VGT_ADDR_RATE:  next_st.rdata = {cfg.adc_khz, cfg.pixel_khz};
                VGT_ADDR_FRAME: next_st.rdata = {6'h00, cfg.active_lines, st.frames};
                default:
                begin
                    next_st.rdata = 32'h0000_0000;
                    next_st.rresp = VGT_RESP_SLVERR;
                end
            endcase
        end
        else if (st.rvalid && s_axi_rready)
            next_st.rvalid = 1'b0;

        // Capture sequencing; trigger edges seen outside ARMED are dropped
        next_st.cap.valid = 1'b0;
        case (st.fsm)
            VGT_IDLE:
                next_st.fsm = VGT_ARMED;
            VGT_ARMED:
            begin
                case (mode)
                    VGT_TRIG_FREE:  next_st.fsm = VGT_WAIT_BOUND;
                    VGT_TRIG_MONO:  if (trig_edge) next_st.fsm = VGT_WAIT_BOUND;
                    VGT_TRIG_CONT:  if (trig_edge) next_st.fsm = VGT_WAIT_BOUND;
                    VGT_TRIG_LEVEL: if (trig_act) next_st.fsm = VGT_WAIT_BOUND;
                    default:        next_st.fsm = VGT_ARMED;
                endcase
            end
            VGT_WAIT_BOUND:
            begin
                if (frame_start)
                begin
                    next_st.fsm     = VGT_CAPTURE;
                    next_st.pix_idx = 2'h1;
                    next_st.cap     = pack(fmt, vid, 2'h0);
                end
            end
            VGT_CAPTURE:
            begin
                if (frame_start)
                begin
                    next_st.frames = st.frames + 16'h0001;
                    if (mode == VGT_TRIG_MONO)
                        next_st.fsm = VGT_ARMED;
                    else if (mode == VGT_TRIG_LEVEL && !trig_act)
                        next_st.fsm = VGT_ARMED;
                    else
                    begin
                        next_st.pix_idx = 2'h1;
                        next_st.cap     = pack(fmt, vid, 2'h0);
                    end
                end
                else if (vid.valid)
                begin
                    next_st.pix_idx = st.pix_idx + 2'h1;
                    next_st.cap     = pack(fmt, vid, st.pix_idx);
                end
            end
            default:
                next_st.fsm = VGT_IDLE;
        endcase
        if (!st.ctrl[VGT_CTRL_EN])
            next_st.fsm = VGT_IDLE;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st      <= '0;
            st.ctrl <= VGT_CTRL_RESET;
            st.gain <= VGT_GAIN_RESET;
        end
        else
            st <= next_st;
    end

    // Timing decode; converter rate entries are twice the pixel rate
    always_comb
    begin
        cfg              = '0;
        cfg.channel      = st.chan[3:0];
        cfg.yc_mode      = st.chan[VGT_CHAN_YC];
        cfg.square       = st.ctrl[VGT_CTRL_SQ];
        cfg.pal          = st.ctrl[VGT_CTRL_PAL];
        cfg.agc_en       = st.ctrl[VGT_CTRL_AGC];
        cfg.gain         = st.gain[7:0];
        cfg.fmt          = fmt;
        cfg.active_lines = cfg.pal ? VGT_PAL_LINES : VGT_NTSC_LINES;
        if (!cfg.square)
        begin
            cfg.total_px  = cfg.pal ? VGT_CCIR_PAL_TOTAL : VGT_CCIR_NTSC_TOTAL;
            cfg.active_px = VGT_CCIR_ACTIVE;
            cfg.pixel_khz = VGT_CCIR_PIX_KHZ;
            cfg.adc_khz   = VGT_CCIR_ADC_KHZ;
        end
        else
        begin
            cfg.total_px  = cfg.pal ? VGT_SQ_PAL_TOTAL : VGT_SQ_NTSC_TOTAL;
            cfg.active_px = cfg.pal ? VGT_SQ_PAL_ACTIVE : VGT_SQ_NTSC_ACTIVE;
            cfg.pixel_khz = cfg.pal ? VGT_SQ_PAL_PIX_KHZ : VGT_SQ_NTSC_PIX_KHZ;
            cfg.adc_khz   = cfg.pal ? VGT_SQ_PAL_ADC_KHZ : VGT_SQ_NTSC_ADC_KHZ;
        end
    end

    assign s_axi_awready = !st.aw_have;
    assign s_axi_wready  = !st.w_have;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;
    assign cap           = st.cap;
    assign grab_active   = st.fsm == VGT_CAPTURE;

    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_armed_edge;
        st.fsm == VGT_ARMED && trig_edge && st.ctrl[VGT_CTRL_EN]
            && (mode == VGT_TRIG_MONO || mode == VGT_TRIG_CONT);
    endsequence

    sequence s_frame_end(vgt_trig_mode_t m);
        st.fsm == VGT_CAPTURE && frame_start && mode == m && st.ctrl[VGT_CTRL_EN];
    endsequence

    a_sync_two_flops: assert property (##2 st.trig_s2 == $past(isolated_trigger_input, 2))
        else $error("trigger synchroniser depth wrong");
    a_edge_arms_wait: assert property (s_armed_edge |=> st.fsm == VGT_WAIT_BOUND)
        else $error("active trigger edge not taken");
    a_hold_boundary: assert property (st.fsm == VGT_WAIT_BOUND && !frame_start |=> !cap.valid)
        else $error("capture began before frame boundary");
    a_mono_one_frame: assert property (s_frame_end(VGT_TRIG_MONO) |=> st.fsm == VGT_ARMED && !cap.valid)
        else $error("monoshot captured past one frame");
    a_cont_keeps_grab: assert property (s_frame_end(VGT_TRIG_CONT) |=> st.fsm == VGT_CAPTURE && cap.valid && cap.sof)
        else $error("continuous grab stopped");
    a_level_stop: assert property (s_frame_end(VGT_TRIG_LEVEL) ##0 !trig_act |=> st.fsm == VGT_ARMED)
        else $error("level grab did not stop");
    a_chan_range: assert property (st.chan[VGT_CHAN_YC] ? 32'(st.chan[3:0]) < NUM_YC : 32'(st.chan[3:0]) < NUM_COMP)
        else $error("channel selection out of range");
    a_yuv_order: assert property (st.fsm == VGT_CAPTURE && vid.valid && !vid.sof && fmt == VGT_FMT_YUV422 && st.pix_idx[0] |=> cap.data[15:8] == $past(vid.v) && cap.data[7:0] == $past(vid.y))
        else $error("4:2:2 sample order wrong");
    a_pad_word: assert property (cap.valid && $past(fmt) == VGT_FMT_RGB32 |-> cap.bytes == 3'h4 && cap.data[31:24] == 8'h00)
        else $error("padded pixel word malformed");
    a_agc_default: assert property ($rose(aresetn) |-> cfg.agc_en)
        else $error("gain control not automatic after reset");
    a_ccir_timing: assert property (!cfg.square && !cfg.pal |-> cfg.total_px == VGT_CCIR_NTSC_TOTAL && cfg.adc_khz == VGT_CCIR_ADC_KHZ)
        else $error("CCIR timing wrong");

endmodule // vgt_grab_ctrl

`default_nettype wire

/* File: test/vgt_video_src.sv */
/*
  Decoder stream and trigger source model for the grab control bench.
  Assumes aclk; a frame is 16 pixels in 48 cycles, every cycle or every other one.
*/
`timescale 1ns/100ps
`default_nettype none
module vgt_video_src
    import vgt_pkg::*;
(
    // Clock, reset and control
    input  wire logic   aclk,
    input  wire logic   aresetn,
    input  wire logic   slow,
    input  wire logic   trig_req,
    // Stream and trigger pin
    output vgt_video_t  vid,
    output logic        isolated_trigger_input
);
    logic [5:0] cyc;
    logic [4:0] p;

    always_ff @(posedge aclk)
    begin
        cyc <= (!aresetn || cyc == 6'd47) ? 6'd0 : cyc + 6'd1;
    end

    // Payload keeps moving in blanking, so stale data never passes for a pixel
    always_comb
    begin
        p = slow ? cyc[5:1] : cyc[4:0];
        vid.valid = aresetn && (slow ? (!cyc[0] && cyc < 6'd32) : cyc < 6'd16);
        vid.sof = vid.valid && p == 5'd0;
        vid.y = {3'h0, p};
        vid.u = 8'h40 + {3'h0, p};
        vid.v = 8'h80 + {3'h0, p};
        vid.r = 8'h10 + {3'h0, p};
        vid.g = 8'h20 + {3'h0, p};
        vid.b = 8'h30 + {3'h0, p};
        isolated_trigger_input = trig_req;
    end
endmodule // vgt_video_src
`default_nettype wire

/* File: test/video_grab_trigger_control_tb.sv */
/*
  Self-checking bench for vgt_grab_ctrl: registers over AXI4-Lite, trigger
  modes, formats. Assumes the stream model in vgt_video_src.
*/
`timescale 1ns/100ps
`default_nettype none
module video_grab_trigger_control_tb
    import vgt_pkg::*;
;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = '0;
    logic [7:0]  araddr = '0;
    logic [31:0] wdata = '0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, trig = 1'b0, slow = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, grab_active, pin;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    vgt_cfg_t    cfg;
    vgt_cap_t    cap, c0, c1;
    vgt_video_t  vid;
    int          num_errors = 0, compares = 0, ncap = 0, base = 0;
    logic [34:0] E0 [5] = '{{3'd3, 32'h0010_2030}, {3'd2, 32'h0000_1106},
        {3'd2, 32'h0000_4000}, {3'd2, 32'h0000_4000}, {3'd4, 32'h0010_2030}};
    logic [34:0] E1 [5] = '{{3'd3, 32'h0011_2131}, {3'd2, 32'h0000_1106},
        {3'd2, 32'h0000_8101}, {3'd1, 32'h0000_0001}, {3'd4, 32'h0011_2131}};
    logic [31:0] LT [4] = '{32'h02D0_035A, 32'h0280_030C, 32'h02D0_0360, 32'h0300_03B0};
    logic [31:0] RT [4] = '{32'h6978_34BC, 32'h5FDC_2FEE, 32'h6978_34BC, 32'h733C_399E};
    logic [31:0] LN [4] = '{32'h01E0_0000, 32'h01E0_0000, 32'h0244_0000, 32'h0244_0000};

    vgt_grab_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .vid(vid), .isolated_trigger_input(pin),
        .cfg(cfg), .cap(cap), .grab_active(grab_active));
    vgt_video_src src (.aclk(aclk), .aresetn(aresetn), .slow(slow), .trig_req(trig),
        .vid(vid), .isolated_trigger_input(pin));

    always #5 aclk = ~aclk;

    // Keeps the first two pixels captured after each test sets base
    always @(posedge aclk)
    begin
        if (cap.valid === 1'b1)
        begin
            if (ncap == base)
                c0 <= cap;
            if (ncap == base + 1)
                c1 <= cap;
            ncap <= ncap + 1;
        end
    end

    task give_verdict;
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
        compares++;
        if (s !== e)
        begin
            num_errors++;
            $display("mismatch at %0t: %s got %h want %h", $time, m, s, e);
        end
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Bready stays high; the old bvalid still reads high in the calling step
        for (n = 0; n < 40; n++)
        begin
            @(posedge aclk);
            if (awready === 1'b1 && awvalid === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1 && wvalid === 1'b1)
                wvalid <= 1'b0;
            if (bvalid === 1'b1)
                break;
        end
        if (n == 40)
        begin
            chk(0, 1, "write timeout");
            give_verdict;
        end
        else
            chk(bresp, r, "bresp");
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                      input logic [1:0] r);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge aclk);
            if (arready === 1'b1 && arvalid === 1'b1)
                arvalid <= 1'b0;
            if (rvalid === 1'b1)
                break;
        end
        if (n == 40)
        begin
            chk(0, 1, "read timeout");
            give_verdict;
        end
        else
        begin
            chk(rresp, r, "rresp");
            chk(rdata & m, e, "rdata");
        end
    endtask

    task automatic t_regs;
        rd(8'h00, 32'h0000_0208, '1, 2'h0);
        rd(8'h08, 32'h0000_0080, '1, 2'h0);
        rd(8'h1C, 32'h0, '1, 2'h2);
        wr(8'h1C, '1, 2'h2);
        wr(8'h0C, '1, 2'h0);
        rd(8'h0C, 32'h0, 32'h0000_0007, 2'h0);
        wr(8'h04, 32'h0000_000B, 2'h0);
        chk(cfg.channel, 32'hB, "top composite");
        wr(8'h04, 32'h0000_000C, 2'h0);
        chk(cfg.channel, 32'hB, "thirteenth kept");
        wr(8'h04, 32'h0000_0015, 2'h0);
        chk({cfg.yc_mode, cfg.channel}, 32'h15, "top pair");
        wr(8'h04, 32'h0000_0016, 2'h0);
        chk({cfg.yc_mode, cfg.channel}, 32'h15, "seventh kept");
        wr(8'h08, 32'h0000_005A, 2'h0);
        wr(8'h00, 32'h0000_0008, 2'h0);
        chk({cfg.agc_en, cfg.gain}, 32'h05A, "manual gain");
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h00, 32'(i) << 4, 2'h0);
            rd(8'h10, LT[i], '1, 2'h0);
            rd(8'h14, RT[i], '1, 2'h0);
            rd(8'h18, LN[i], 32'h03FF_0000, 2'h0);
            chk({6'h00, cfg.active_px, 6'h00, cfg.total_px}, LT[i], "cfg px");
            chk({cfg.adc_khz, cfg.pixel_khz}, RT[i], "cfg rate");
        end
        $display("registers done");
    endtask

    task automatic t_mono(input int f);
        logic [31:0] m0, m1;
        m0 = 32'hFFFF_FFFF >> (32 - 8 * E0[f][34:32]);
        m1 = 32'hFFFF_FFFF >> (32 - 8 * E1[f][34:32]);
        base = ncap;
        wr(8'h00, 32'h0000_020B | (32'(f) << 6), 2'h0);
        chk(cfg.fmt, f, "fmt select");
        rd(8'h0C, 32'h0000_0001, 32'h0000_0007, 2'h0);
        waitc(3);
        trig <= 1'b1;
        waitc(200);
        trig <= 1'b0;
        chk(ncap - base, 16, "mono count");
        chk(grab_active, 0, "mono stop");
        chk(c0.sof, 1, "aligned start");
        chk(c0.bytes, E0[f][34:32], "bytes0");
        chk(c0.data & m0, E0[f][31:0], "pixel0");
        chk(c1.bytes, E1[f][34:32], "bytes1");
        chk(c1.data & m1, E1[f][31:0], "pixel1");
        wr(8'h00, 32'h0000_0208, 2'h0);
        $display("monoshot format %0d done", f);
    endtask

    task automatic t_cont;
        base = ncap;
        slow <= 1'b1;
        trig <= 1'b1;
        wr(8'h00, 32'h0000_0205, 2'h0);
        waitc(3);
        trig <= 1'b0;
        waitc(250);
        chk(ncap - base >= 48, 1, "cont frames");
        chk(grab_active, 1, "cont running");
        wr(8'h00, 32'h0000_0204, 2'h0);
        waitc(2);
        chk(grab_active, 0, "cont stopped");
        slow <= 1'b0;
        $display("continuous done");
    endtask

    task automatic t_level;
        base = ncap;
        trig <= 1'b1;
        wr(8'h00, 32'h0000_0207, 2'h0);
        waitc(150);
        chk(ncap - base, 0, "inactive level");
        wr(8'h00, 32'h0000_020F, 2'h0);
        waitc(200);
        trig <= 1'b0;
        waitc(150);
        chk((ncap - base) % 16, 0, "whole frames");
        chk(ncap - base >= 32, 1, "level frames");
        chk(grab_active, 0, "level stop");
        // Free-run ignores the pin and starts at the next frame
        wr(8'h00, 32'h0000_0209, 2'h0);
        waitc(100);
        chk(grab_active, 1, "free run");
        wr(8'h00, 32'h0000_0208, 2'h0);
        $display("level done");
    endtask

    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs;
        for (int f = 0; f < 5; f++)
            t_mono(f);
        t_cont;
        t_level;
        give_verdict;
    end
endmodule // video_grab_trigger_control_tb
`default_nettype wire
